/* File: hw/circ_pkg.sv */
// Package for the CPU interface and reset control block.
// Assumes a 100 MHz core clock, taken as the CPU double-rate clock.
package circ_pkg;
    // Register byte addresses
    localparam logic [3:0] CIRC_ADDR_CTRL = 4'h0;
    localparam logic [3:0] CIRC_ADDR_STATUS = 4'h4;
    localparam logic [3:0] CIRC_ADDR_CMD = 4'h8;
    // Control register field positions
    localparam int CIRC_CTRL_FAST_BIT = 0;
    localparam int CIRC_CTRL_PORT92_BIT = 1;
    localparam int CIRC_CTRL_COPRO_BIT = 2;
    localparam logic [31:0] CIRC_CTRL_RESET = 32'h00000001;
    // Command codes, written as port and data
    localparam logic [7:0] CIRC_PORT_FAST = 8'h92;
    localparam logic [7:0] CIRC_PORT_HOT = 8'hEF;
    localparam logic [7:0] CIRC_PORT_KBD = 8'h64;
    localparam logic [7:0] CIRC_KBD_CMD_A = 8'hFC;
    localparam logic [7:0] CIRC_KBD_CMD_B = 8'hFE;
    // Timing
    localparam int CIRC_CLK_MHZ = 100;
    localparam int CIRC_FAST_DELAY_NS = 6720;
    localparam int CIRC_SLOW_DELAY_NS = 50000;
    localparam int CIRC_FAST_DELAY_CYC = (CIRC_FAST_DELAY_NS * CIRC_CLK_MHZ) / 1000;
    localparam int CIRC_SLOW_DELAY_CYC = (CIRC_SLOW_DELAY_NS * CIRC_CLK_MHZ) / 1000;
    localparam int CIRC_RESET_PULSE_CYC = 16;
    localparam int CIRC_BUSY_MARGIN_CYC = 8;
    localparam int CIRC_STROBE_EDGES = 4;
    // Cycle kinds on the CPU bus and reset sequencer states
    typedef enum logic [1:0] {CIRC_CYC_IDLE, CIRC_CYC_DRAM, CIRC_CYC_SLOT} circ_cyc_t;
    typedef enum logic [2:0] {CIRC_RS_IDLE, CIRC_RS_WAIT, CIRC_RS_PRE, CIRC_RS_PULSE, CIRC_RS_POST} circ_rst_t;
endpackage : circ_pkg

/* File: hw/circ_top.sv */
// CPU interface and reset control: cycle steering, hold relay, reset sequencing.
// Assumes DRAM and slot controllers on the same clock; pins arrive asynchronous.
//
// Function
// - Strap at power-on selects processor variant
// - Latch status and address on strobe
// - Onboard memory: bank request, done on transfer
// - Done output joins CPU ready externally
// - IO and offboard memory become slot cycles
// - Hold ready during slot; no overlap
// - DMA hold relayed; ack granted after CPU
// - Refresh timer requests hold too
// - System reset drives bus, CPU, coprocessor
// - Bus reset on oscillator edge, strobes off
// - Strobes back after fourth strobe fall
// - Port 92 bit0 or EF read: delayed reset; here a write with ctrl bit 1 set, or any read of the command register
// - Keyboard command reset, fast or slow delay
// - Shutdown cycle causes CPU-only reset
// - CPU-only reset lasts sixteen clocks
// - Busy request brackets system CPU reset
// - No busy request on CPU-only reset
// - Bus reset released with power good
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module circ_top
    import circ_pkg::*;
#(
    parameter int SLOW_DELAY_CYC = CIRC_SLOW_DELAY_CYC,
    parameter int ADDR_W = 24
)
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Avalon-MM slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // CPU bus pins
    input wire logic i_cpu_addr_strobe_n,
    input wire logic i_cpu_status_line1_n,
    input wire logic i_cpu_mio,
    input wire logic i_cpu_wr,
    input wire logic i_cpu_dc,
    input wire logic [ADDR_W-1:0] i_cpu_addr,
    input wire logic i_dram_write_strobe_strap,
    input wire logic i_power_ok_in,
    input wire logic i_bus_oscillator_in,
    input wire logic i_cpu_hold_ack,
    output logic o_cycle_done_out_n,
    output logic o_cpu_hold_req,
    output logic o_cpu_reset_out,
    output logic o_copro_reset_out,
    output logic o_bus_reset_out,
    output logic o_strobe_enable,
    output logic o_cpu_busy_out_n,
    output logic o_mode_32bit,
    // Internal controllers
    input wire logic i_onboard_hit,
    input wire logic i_dram_done,
    input wire logic i_slot_done,
    input wire logic i_dma_hold_req_int,
    input wire logic i_timer_ch1_output,
    output logic o_bank_req,
    output logic o_slot_req,
    output logic [ADDR_W-1:0] o_cyc_addr,
    output logic [2:0] o_cyc_status,
    output logic o_dma_hold_ack_int
);
    // Elaboration check; the delay counters are 16 bits wide
    if (ADDR_W < 16 || ADDR_W > 32 || SLOW_DELAY_CYC < CIRC_FAST_DELAY_CYC || SLOW_DELAY_CYC > 65535)
    begin : g_param_check
        $error("circ_top: unsupported parameter values");
    end

    // Pin synchronisers, two stages each
    logic [5:0] sync1;
    logic [5:0] sync2;
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync1 <= 6'h30; // Idle levels, power low, no false edges
            sync2 <= 6'h30;
        end
        else
        begin
            sync1 <= {i_cpu_addr_strobe_n, i_cpu_status_line1_n, i_power_ok_in, i_bus_oscillator_in,
                      i_cpu_hold_ack, i_dram_write_strobe_strap};
            sync2 <= sync1;
        end
    end
    logic ads_n_s, s1_n_s, pwr_s, osc_s, cpu_hold_ack_s, strap_s;
    assign ads_n_s = sync2[5];
    assign s1_n_s = sync2[4];
    assign pwr_s = sync2[3];
    assign osc_s = sync2[2];
    assign cpu_hold_ack_s = sync2[1];
    assign strap_s = sync2[0];

    // Edge history
    logic ads_d, s1_d, osc_d, pwr_d;
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ads_d <= 1'b1;
            s1_d <= 1'b1;
            osc_d <= 1'b0;
            pwr_d <= 1'b0;
        end
        else
        begin
            ads_d <= ads_n_s;
            s1_d <= s1_n_s;
            osc_d <= osc_s;
            pwr_d <= pwr_s;
        end
    end
    logic ads_fall, s1_fall, osc_rise, pwr_rise;
    assign ads_fall = ads_d && !ads_n_s;
    assign s1_fall = s1_d && !s1_n_s;
    assign osc_rise = !osc_d && osc_s;
    assign pwr_rise = !pwr_d && pwr_s;

    // Processor strap taken once as power comes good
    logic strap_taken;
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_mode_32bit <= 1'b0;
            strap_taken <= 1'b0;
        end
        else if (!strap_taken && pwr_rise)
        begin
            o_mode_32bit <= strap_s;
            strap_taken <= 1'b1;
        end
    end

    // Cycle start: address strobe in 32-bit mode, status one in 16-bit mode
    logic cyc_start;
    assign cyc_start = o_mode_32bit ? ads_fall : s1_fall;

    // Shutdown decode differs per processor
    function automatic logic circ_is_shutdown(input logic m32, input logic mio, input logic dc,
                                              input logic wr, input logic [ADDR_W-1:0] a);
        if (m32)
            circ_is_shutdown = mio && !dc && wr && (a[1:0] == 2'h0);
        else
            circ_is_shutdown = !mio && !dc && !wr && (a[1] == 1'b0);
    endfunction : circ_is_shutdown

    // Cycle latch and steering
    circ_cyc_t cyc;
    logic shutdown_hit;
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cyc <= CIRC_CYC_IDLE;
            o_cyc_addr <= '0;
            o_cyc_status <= 3'h0;
            o_bank_req <= 1'b0;
            o_slot_req <= 1'b0;
            o_cycle_done_out_n <= 1'b1;
            shutdown_hit <= 1'b0;
        end
        else
        begin
            o_cycle_done_out_n <= 1'b1;
            shutdown_hit <= 1'b0;
            case (cyc)
                CIRC_CYC_IDLE:
                    if (cyc_start && !o_cpu_reset_out)
                    begin
                        o_cyc_addr <= i_cpu_addr;
                        o_cyc_status <= {i_cpu_mio, i_cpu_dc, i_cpu_wr};
                        if (circ_is_shutdown(o_mode_32bit, i_cpu_mio, i_cpu_dc, i_cpu_wr, i_cpu_addr))
                        begin
                            shutdown_hit <= 1'b1;
                            o_cycle_done_out_n <= 1'b0;
                        end
                        else if (i_cpu_mio && i_onboard_hit)
                        begin
                            cyc <= CIRC_CYC_DRAM;
                            o_bank_req <= 1'b1;
                        end
                        else
                        begin
                            cyc <= CIRC_CYC_SLOT;
                            o_slot_req <= 1'b1;
                        end
                    end
                CIRC_CYC_DRAM:
                    if (i_dram_done)
                    begin
                        o_bank_req <= 1'b0;
                        o_cycle_done_out_n <= 1'b0;
                        cyc <= CIRC_CYC_IDLE;
                    end
                CIRC_CYC_SLOT:
                    if (i_slot_done)
                    begin
                        o_slot_req <= 1'b0;
                        o_cycle_done_out_n <= 1'b0;
                        cyc <= CIRC_CYC_IDLE;
                    end
                default:
                    cyc <= CIRC_CYC_IDLE;
            endcase
        end
    end

    // Hold relay for DMA and refresh
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_cpu_hold_req <= 1'b0;
            o_dma_hold_ack_int <= 1'b0;
        end
        else
        begin
            o_cpu_hold_req <= i_dma_hold_req_int || i_timer_ch1_output;
            o_dma_hold_ack_int <= i_dma_hold_req_int && o_cpu_hold_req && cpu_hold_ack_s;
        end
    end

    // Bus reset follows power good on oscillator rise
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_bus_reset_out <= 1'b1;
        else if (osc_rise)
            o_bus_reset_out <= !pwr_s;
    end

    // Strobe outputs off in reset, back after fourth strobe fall
    logic [2:0] edge_cnt;
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_strobe_enable <= 1'b0;
            edge_cnt <= 3'h0;
        end
        else if (o_bus_reset_out || (osc_rise && !pwr_s))
        begin
            o_strobe_enable <= 1'b0;
            edge_cnt <= 3'h0;
        end
        else if (!o_strobe_enable && cyc_start)
        begin
            if (edge_cnt == 3'(CIRC_STROBE_EDGES - 1))
                o_strobe_enable <= 1'b1;
            edge_cnt <= edge_cnt + 3'h1;
        end
    end

    // Avalon slave: one wait cycle, then answer
    logic [31:0] ctrl;
    logic hot_req, kbd_req;
    logic acc_done;
    logic acc;
    assign acc = (i_avs_read || i_avs_write) && !acc_done;
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            acc_done <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h00000000;
            ctrl <= CIRC_CTRL_RESET;
            hot_req <= 1'b0;
            kbd_req <= 1'b0;
        end
        else
        begin
            hot_req <= 1'b0;
            kbd_req <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            acc_done <= 1'b0;
            if (acc)
            begin
                o_avs_waitrequest <= 1'b0;
                acc_done <= 1'b1;
                o_avs_readdata <= 32'h00000000;
                if (i_avs_address == CIRC_ADDR_CTRL)
                begin
                    if (i_avs_write)
                    begin
                        ctrl <= {29'h0, i_avs_writedata[2:0]};
                        if (i_avs_writedata[CIRC_CTRL_PORT92_BIT])
                            hot_req <= 1'b1;
                    end
                    o_avs_readdata <= ctrl;
                end
                else if (i_avs_address == CIRC_ADDR_STATUS)
                    o_avs_readdata <= {26'h0, o_strobe_enable, o_bus_reset_out, o_cpu_reset_out,
                                       o_mode_32bit, cyc == CIRC_CYC_SLOT, cyc == CIRC_CYC_DRAM};
                else if (i_avs_address == CIRC_ADDR_CMD)
                begin
                    if (i_avs_write && i_avs_writedata[15:8] == CIRC_PORT_KBD
                        && (i_avs_writedata[7:0] == CIRC_KBD_CMD_A || i_avs_writedata[7:0] == CIRC_KBD_CMD_B))
                        kbd_req <= 1'b1;
                    if (i_avs_read && i_avs_writedata[15:8] == CIRC_PORT_HOT)
                        hot_req <= 1'b1;
                    if (i_avs_read)
                        hot_req <= 1'b1;
                end
            end
        end
    end

    // Reset sequencer: system and CPU-only resets
    circ_rst_t rs;
    logic [15:0] rcnt;
    logic sys_seq;
    logic [15:0] slow_cyc;
    assign slow_cyc = 16'(SLOW_DELAY_CYC);
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rs <= CIRC_RS_IDLE;
            rcnt <= 16'h0000;
            sys_seq <= 1'b0;
            o_cpu_reset_out <= 1'b1;
            o_copro_reset_out <= 1'b1;
            o_cpu_busy_out_n <= 1'b1;
        end
        else if (!pwr_s)
        begin
            rs <= CIRC_RS_PRE;
            rcnt <= 16'h0000;
            sys_seq <= 1'b1;
            o_cpu_reset_out <= 1'b1;
            o_copro_reset_out <= 1'b1;
            o_cpu_busy_out_n <= 1'b0;
        end
        else
        begin
            case (rs)
                CIRC_RS_IDLE:
                begin
                    o_copro_reset_out <= ctrl[CIRC_CTRL_COPRO_BIT];
                    if (hot_req || shutdown_hit || kbd_req)
                    begin
                        rs <= CIRC_RS_WAIT;
                        sys_seq <= 1'b0;
                        rcnt <= shutdown_hit ? 16'h0001
                              : (kbd_req && !ctrl[CIRC_CTRL_FAST_BIT]) ? slow_cyc
                              : 16'(CIRC_FAST_DELAY_CYC);
                    end
                end
                CIRC_RS_WAIT:
                    if (rcnt <= 16'h0001)
                    begin
                        rs <= CIRC_RS_PULSE;
                        rcnt <= 16'(CIRC_RESET_PULSE_CYC);
                        o_cpu_reset_out <= 1'b1;
                    end
                    else
                        rcnt <= rcnt - 16'h0001;
                CIRC_RS_PRE:
                    if (rcnt == 16'(CIRC_BUSY_MARGIN_CYC))
                    begin
                        rs <= CIRC_RS_PULSE;
                        rcnt <= 16'(CIRC_RESET_PULSE_CYC);
                    end
                    else
                        rcnt <= rcnt + 16'h0001;
                CIRC_RS_PULSE:
                    if (rcnt == 16'h0001)
                    begin
                        o_cpu_reset_out <= 1'b0;
                        o_copro_reset_out <= ctrl[CIRC_CTRL_COPRO_BIT];
                        rcnt <= 16'(CIRC_BUSY_MARGIN_CYC);
                        rs <= sys_seq ? CIRC_RS_POST : CIRC_RS_IDLE;
                    end
                    else
                        rcnt <= rcnt - 16'h0001;
                CIRC_RS_POST:
                    if (rcnt == 16'h0001)
                    begin
                        o_cpu_busy_out_n <= 1'b1;
                        sys_seq <= 1'b0;
                        rs <= CIRC_RS_IDLE;
                    end
                    else
                        rcnt <= rcnt - 16'h0001;
                default:
                    rs <= CIRC_RS_IDLE;
            endcase
        end
    end
endmodule : circ_top

/* File: tb/circ_top_sva.sv */
// Checker for the CPU interface and reset block.
// Sees only the top ports; bound into every instance of the top.
`timescale 1ns/1ps
module circ_top_sva
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Watched inputs
    input wire logic i_dram_done,
    input wire logic i_slot_done,
    input wire logic i_dma_hold_req_int,
    input wire logic i_timer_ch1_output,
    // Watched outputs
    input wire logic o_bank_req,
    input wire logic o_slot_req,
    input wire logic o_cycle_done_out_n,
    input wire logic o_cpu_hold_req,
    input wire logic o_dma_hold_ack_int,
    input wire logic o_cpu_reset_out,
    input wire logic o_cpu_busy_out_n,
    input wire logic o_bus_reset_out,
    input wire logic o_strobe_enable
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    logic [15:0] rst_cnt;
    logic [15:0] busy_cnt;
    // Run lengths of CPU reset high and busy low
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_cnt <= 16'h0000;
            busy_cnt <= 16'h0000;
        end
        else
        begin
            rst_cnt <= o_cpu_reset_out ? rst_cnt + 16'h0001 : 16'h0000;
            busy_cnt <= !o_cpu_busy_out_n ? busy_cnt + 16'h0001 : 16'h0000;
        end
    end
    chk_dram_done: assert property (o_bank_req && i_dram_done |=> !o_cycle_done_out_n)
        else $error("no done after memory transfer");
    chk_slot_done: assert property (o_slot_req && i_slot_done |=> !o_cycle_done_out_n)
        else $error("no done after slot transfer");
    chk_done_pulse: assert property (!o_cycle_done_out_n |=> o_cycle_done_out_n)
        else $error("done wider than one clock");
    chk_hold_relay: assert property (o_cpu_hold_req == $past(i_dma_hold_req_int | i_timer_ch1_output))
        else $error("hold request not relayed");
    chk_dma_grant: assert property (o_dma_hold_ack_int |-> $past(o_cpu_hold_req && i_dma_hold_req_int))
        else $error("grant without request");
    chk_strobe_off: assert property (o_bus_reset_out |-> !o_strobe_enable)
        else $error("strobes driven in bus reset");
    chk_reset_width: assert property ($fell(o_cpu_reset_out) && o_cpu_busy_out_n |-> rst_cnt == 16'h0010)
        else $error("cpu-only reset not sixteen clocks");
    chk_busy_lead: assert property ($fell(o_cpu_reset_out) && !o_cpu_busy_out_n |-> busy_cnt >= 16'h0008)
        else $error("busy too short before reset fall");
    chk_busy_trail: assert property ($fell(o_cpu_reset_out) && !o_cpu_busy_out_n |-> !o_cpu_busy_out_n [*8])
        else $error("busy released too early");
    chk_no_selftest: assert property ($rose(o_cpu_reset_out) && o_cpu_busy_out_n |-> o_cpu_busy_out_n [*8])
        else $error("busy raised on cpu-only reset");
endmodule : circ_top_sva

bind circ_top circ_top_sva u_sva (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_dram_done(i_dram_done),
    .i_slot_done(i_slot_done), .i_dma_hold_req_int(i_dma_hold_req_int), .i_timer_ch1_output(i_timer_ch1_output),
    .o_bank_req(o_bank_req), .o_slot_req(o_slot_req), .o_cycle_done_out_n(o_cycle_done_out_n),
    .o_cpu_hold_req(o_cpu_hold_req), .o_dma_hold_ack_int(o_dma_hold_ack_int), .o_cpu_reset_out(o_cpu_reset_out),
    .o_cpu_busy_out_n(o_cpu_busy_out_n), .o_bus_reset_out(o_bus_reset_out), .o_strobe_enable(o_strobe_enable));

/* File: tb/circ_cpu_model.sv */
// Host CPU model: runs bus cycles and answers hold requests.
// Assumes the block clock is the CPU double-rate clock.
`timescale 1ns/1ps
module circ_cpu_model
#(
    parameter int ACK_LAT = 3
)
(
    // Clock and mode
    input wire logic i_ref_clk,
    input wire logic i_mode_32bit,
    // From the block
    input wire logic i_cpu_hold_req,
    input wire logic i_cycle_done_out_n,
    // To the block
    output logic o_cpu_addr_strobe_n = 1'b1,
    output logic o_cpu_status_line1_n = 1'b1,
    output logic o_cpu_mio = 1'b0,
    output logic o_cpu_wr = 1'b0,
    output logic o_cpu_dc = 1'b0,
    output logic [23:0] o_cpu_addr = 24'h000000,
    output logic o_cpu_hold_ack
);
    logic [7:0] hold_pipe = 8'h00;
    // Bus handed over a few clocks after the request
    always @(posedge i_ref_clk)
    begin
        hold_pipe <= {hold_pipe[6:0], i_cpu_hold_req};
    end
    assign o_cpu_hold_ack = hold_pipe[ACK_LAT-1];
    // One bus cycle; n counts clocks until done is seen
    task automatic run_cycle(input logic [2:0] st, input logic [23:0] a, output int n);
        n = 0;
        {o_cpu_mio, o_cpu_dc, o_cpu_wr} <= st;
        o_cpu_addr <= a;
        o_cpu_addr_strobe_n <= !i_mode_32bit;
        o_cpu_status_line1_n <= i_mode_32bit;
        repeat (2) @(posedge i_ref_clk);
        o_cpu_addr_strobe_n <= 1'b1;
        o_cpu_status_line1_n <= 1'b1;
        while (i_cycle_done_out_n !== 1'b0 && n < 100)
        begin
            @(posedge i_ref_clk);
            n++;
        end
        o_cpu_addr <= ~a;
        @(posedge i_ref_clk);
    endtask : run_cycle
endmodule : circ_cpu_model

/* File: tb/circ_top_tb_top.sv */
// Testbench for the CPU interface and reset block.
// Drives registers over Avalon-MM; a CPU model runs bus cycles.
`timescale 1ns/1ps
module circ_top_tb_top;
    import circ_pkg::*;
    localparam int SLOW = 700;
    logic clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [3:0] av_a = 4'h0;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_d = 32'h00000000;
    logic [31:0] av_q;
    logic av_wait;
    logic as_n, s1_n, mio, wr, dc, hold_ack, done_n, hold_req, cpu_rst, copro_rst, bus_rst, strobe_en, busy_n, mode32;
    logic strap = 1'b1, power_ok = 1'b0, osc = 1'b0, onboard = 1'b1, dram_done = 1'b0, slot_done = 1'b0;
    logic dma_req = 1'b0, timer1 = 1'b0, bank_req, slot_req, dma_ack;
    logic [23:0] addr, cyc_addr;
    logic [2:0] cyc_st;
    logic [31:0] rd;
    int err_total = 0;
    int comparisons = 0;
    int n;
    int slot_wait = 0;
    circ_top #(.SLOW_DELAY_CYC(SLOW)) u_dut (.i_ref_clk(clk), .i_rst_n(i_rst_n), .i_avs_address(av_a),
        .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_d), .o_avs_readdata(av_q),
        .o_avs_waitrequest(av_wait), .i_cpu_addr_strobe_n(as_n), .i_cpu_status_line1_n(s1_n), .i_cpu_mio(mio),
        .i_cpu_wr(wr), .i_cpu_dc(dc), .i_cpu_addr(addr), .i_dram_write_strobe_strap(strap),
        .i_power_ok_in(power_ok), .i_bus_oscillator_in(osc), .i_cpu_hold_ack(hold_ack),
        .o_cycle_done_out_n(done_n), .o_cpu_hold_req(hold_req), .o_cpu_reset_out(cpu_rst),
        .o_copro_reset_out(copro_rst), .o_bus_reset_out(bus_rst), .o_strobe_enable(strobe_en),
        .o_cpu_busy_out_n(busy_n), .o_mode_32bit(mode32), .i_onboard_hit(onboard), .i_dram_done(dram_done),
        .i_slot_done(slot_done), .i_dma_hold_req_int(dma_req), .i_timer_ch1_output(timer1),
        .o_bank_req(bank_req), .o_slot_req(slot_req), .o_cyc_addr(cyc_addr), .o_cyc_status(cyc_st),
        .o_dma_hold_ack_int(dma_ack));
    circ_cpu_model u_cpu (.i_ref_clk(clk), .i_mode_32bit(mode32), .i_cpu_hold_req(hold_req),
        .i_cycle_done_out_n(done_n), .o_cpu_addr_strobe_n(as_n), .o_cpu_status_line1_n(s1_n), .o_cpu_mio(mio),
        .o_cpu_wr(wr), .o_cpu_dc(dc), .o_cpu_addr(addr), .o_cpu_hold_ack(hold_ack));
    // Clock and slower bus oscillator
    initial forever #5 clk = ~clk;
    initial forever #35 osc = ~osc;
    // Memory answers at once, slot bus after several clocks
    always @(posedge clk)
    begin
        dram_done <= bank_req && !dram_done;
        slot_wait <= slot_req ? slot_wait + 1 : 0;
        slot_done <= slot_req && slot_wait == 6;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("Comparisons %0d, errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    // Bounded wait for a level; running out is an error
    task automatic wait_for(input string what, ref logic sig, input logic lvl, input int lim, output int k);
        k = 0;
        while (sig !== lvl && k < lim)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= lim)
        begin
            check(what, 32'h0, 32'h1);
            test_done();
        end
    endtask : wait_for
    // One Avalon access, held until waitrequest is sampled low
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        av_a <= a;
        av_d <= d;
        av_wr <= w;
        av_rd <= !w;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (av_wait !== 1'b0 && k < 50);
        q = av_q;
        if (k >= 50)
            wait_for("bus answer", av_wait, 1'b0, 0, k);
        av_wr <= 1'b0;
        av_rd <= 1'b0;
        @(posedge clk);
    endtask : av
    // Delay to a CPU-only reset, its width and quiet busy
    task automatic reset_seen(input int dly);
        int k;
        wait_for("reset start", cpu_rst, 1'b1, dly + 30, k);
        check("reset delay", k >= dly - 2 && k <= dly + 10, 1);
        wait_for("reset end", cpu_rst, 1'b0, 40, k);
        check("reset width", k, 16);
        check("busy quiet", busy_n, 1);
    endtask : reset_seen
    initial
    begin
        repeat (20) @(posedge clk);
        i_rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        check("resets", {bus_rst, cpu_rst, copro_rst}, 3'h7);
        check("strobes off", strobe_en, 0);
        check("self-test", busy_n, 0);
        power_ok <= 1'b1;
        wait_for("bus release", bus_rst, 1'b0, 300, n);
        wait_for("cpu release", cpu_rst, 1'b0, 300, n);
        wait_for("busy release", busy_n, 1'b1, 300, n);
        strap <= 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            check("strobes idle", strobe_en, 0);
            u_cpu.run_cycle(3'b110, 24'h000100 + 24'(k), n);
            check("dram cycle", n < 100, 1);
            check("latched addr", cyc_addr, 24'h000100 + 24'(k));
        end
        check("strobes on", strobe_en, 1);
        check("mode", mode32, 1);
        onboard <= 1'b0;
        u_cpu.run_cycle(3'b010, 24'h000060, n);
        check("slot ready held", n >= 6 && n < 100, 1);
        check("slot status", cyc_st, 3'b010);
        dma_req <= 1'b1;
        wait_for("dma grant", dma_ack, 1'b1, 20, n);
        dma_req <= 1'b0;
        wait_for("grant drop", dma_ack, 1'b0, 20, n);
        timer1 <= 1'b1;
        wait_for("refresh hold", hold_req, 1'b1, 3, n);
        timer1 <= 1'b0;
        av(1'b0, CIRC_ADDR_CTRL, 32'h0, rd);
        check("ctrl reset", rd, CIRC_CTRL_RESET);
        av(1'b0, 4'hC, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        av(1'b0, CIRC_ADDR_STATUS, 32'h0, rd);
        check("status", rd, 32'h00000024);
        av(1'b1, CIRC_ADDR_CMD, {16'h0, CIRC_PORT_KBD, CIRC_KBD_CMD_B}, rd);
        reset_seen(CIRC_FAST_DELAY_CYC);
        av(1'b1, CIRC_ADDR_CTRL, 32'h0, rd);
        av(1'b1, CIRC_ADDR_CMD, {16'h0, CIRC_PORT_KBD, CIRC_KBD_CMD_A}, rd);
        reset_seen(SLOW);
        av(1'b0, CIRC_ADDR_CMD, 32'h0, rd);
        reset_seen(CIRC_FAST_DELAY_CYC);
        av(1'b1, CIRC_ADDR_CTRL, 32'h3, rd);
        reset_seen(CIRC_FAST_DELAY_CYC);
        onboard <= 1'b1;
        u_cpu.run_cycle(3'b101, 24'h000000, n);
        reset_seen(1);
        av(1'b1, 4'hC, 32'hFFFFFFFF, rd);
        av(1'b1, CIRC_ADDR_CTRL, 32'h5, rd);
        repeat (4) @(posedge clk);
        check("copro alone", {copro_rst, cpu_rst, bus_rst}, 3'h4);
        // Second power-on with the strap low: 16-bit cycles
        i_rst_n <= 1'b0;
        power_ok <= 1'b0;
        repeat (20) @(posedge clk);
        i_rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        check("resets again", {bus_rst, cpu_rst, busy_n}, 3'h6);
        power_ok <= 1'b1;
        wait_for("busy again", busy_n, 1'b1, 300, n);
        check("mode 16", mode32, 0);
        u_cpu.run_cycle(3'b000, 24'h000000, n);
        reset_seen(1);
        test_done();
    end
endmodule : circ_top_tb_top
